// ---- shared/core_pkg.sv ----
package core_pkg;
  // Mode codes of the five-bit mode field
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [4:0] MODE_FIQ  = 5'h11;
  localparam logic [4:0] MODE_IRQ  = 5'h12;
  localparam logic [4:0] MODE_SVC  = 5'h13;
  localparam logic [4:0] MODE_ABT  = 5'h17;
  localparam logic [4:0] MODE_UND  = 5'h1b;
  localparam logic [4:0] MODE_SYS  = 5'h1f;

  // Status word field masks
  localparam logic [31:0] MASK_MODE     = 32'h0000_001f;
  localparam logic [31:0] MASK_COMPACT  = 32'h0000_0020;
  localparam logic [31:0] MASK_FIQ_DIS  = 32'h0000_0040;
  localparam logic [31:0] MASK_IRQ_DIS  = 32'h0000_0080;
  localparam logic [31:0] MASK_BYTECODE = 32'h0100_0000;
  localparam logic [31:0] MASK_STATE    = MASK_COMPACT | MASK_BYTECODE;
  localparam logic [31:0] STATUS_RESET  = 32'h0000_00d3;

  // Exception vectors
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UND   = 32'h0000_0004;
  localparam logic [31:0] VEC_SOFT  = 32'h0000_0008;
  localparam logic [31:0] VEC_PABT  = 32'h0000_000c;
  localparam logic [31:0] VEC_DABT  = 32'h0000_0010;
  localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ   = 32'h0000_001c;

  // Alignment and fetch steps
  localparam logic [31:0] ALIGN_WORD = 32'h0000_0003;
  localparam logic [31:0] ALIGN_HALF = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD  = 32'h0000_0004;
  localparam logic [31:0] STEP_HALF  = 32'h0000_0002;

  // Tightly coupled memory windows
  localparam logic [31:0] CPL_MASK  = 32'hfff0_0000;
  localparam logic [31:0] ICPL_BASE = 32'h0000_0000;
  localparam logic [31:0] DCPL_BASE = 32'h0010_0000;

  // Bank geometry
  localparam int         NUM_GPR    = 30;
  localparam logic [2:0] SAVED_NONE = 3'h7;
  localparam logic [3:0] IDX_FIRST_BANKED = 4'h8;
  localparam logic [3:0] IDX_SP     = 4'hd;
  localparam logic [3:0] IDX_LR     = 4'he;
  localparam logic [3:0] IDX_PC     = 4'hf;
  localparam logic [4:0] PHYS_FIQ_HI = 5'h0d;
  localparam logic [4:0] PHYS_BANKED = 5'h12;
  localparam logic [2:0] DEPTH_NATIVE   = 3'h5;
  localparam logic [2:0] DEPTH_BYTECODE = 3'h6;

  // Register port offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SAVED  = 8'h04;
  localparam logic [7:0] OFS_INFO   = 8'h08;
  localparam logic [7:0] OFS_FAULT  = 8'h0c;

  typedef enum logic [1:0] {st_wide = 2'b00, st_compact = 2'b01, st_bytecode = 2'b10} istate_e;
  typedef enum logic [1:0] {sz_byte = 2'b00, sz_half = 2'b01, sz_word = 2'b10} size_e;
  typedef enum logic [1:0] {
    br_exchange = 2'b00, br_link_exchange = 2'b01, br_load_pc = 2'b10, br_to_bytecode = 2'b11
  } br_kind_e;

  typedef struct packed {
    logic        valid;
    logic        exc_return;
    br_kind_e    kind;
    logic [31:0] target;
    logic [31:0] link;
  } branch_s;

  typedef struct packed {
    logic data_abort;
    logic fiq;
    logic irq;
    logic prefetch_abort;
    logic breakpoint;
    logic undefined;
    logic soft_int;
  } exc_req_s;

  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic [3:0]  idx;
    logic [31:0] data;
  } dest_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    size_e       size;
    logic [31:0] addr;
  } mem_req_s;

  typedef struct packed {
    logic        valid;
    logic        coupled;
    size_e       size;
    logic [31:0] addr;
  } bus_req_s;
endpackage

// ---- core/core_state_mode_register_bank.sv ----
// How it works
// - three states: wide, compact, bytecode
// - bytecode fetches are always whole words
// - exchange branches, pc loads flip wide/compact
// - only bytecode branch from wide, or exception return, enters bytecode state
// - exceptions always run in wide state
// - exception return restores previous state
// - five one-cycle stages in native states
// - bytecode decode stage takes two cycles
// - byte, half, word accesses with alignment
// - load-use stalls, other hazards forward
// - rare bytecodes expand into native sequences
// - interrupt in bytecode returns to wide
// - seven modes; system shares user view
// - aborts enter abort, undefined enters undefined
// - software or exceptions change mode; privilege
// - 31 general plus 6 status registers
// - separate instruction/data bus and coupled-memory paths
// - shared r0-r7, fiq banks r8-r14
// - entry saves lr, status, sets vector
// - fixed priority among simultaneous exceptions
// - five-bit mode field, bytecode, compact flags
`timescale 1ns/1ps
module core_state_mode_register_bank (
  input  wire logic          ref_clk_in,
  input  wire logic          reset_n_in,
  input  wire logic [7:0]    reg_addr_in,
  input  wire logic [31:0]   reg_wdata_in,
  input  wire logic          reg_write_in,
  input  wire logic          reg_read_in,
  output logic [31:0]        reg_rdata_out,
  input  core_pkg::branch_s  branch_in,
  input  core_pkg::exc_req_s exc_req_in,
  input  wire logic [31:0]   exc_ret_addr_in,
  input  wire logic          bytecode_rare_in,
  input  wire logic [3:0]    seq_len_in,
  input  wire logic [3:0]    rd_a_idx_in,
  input  wire logic [3:0]    rd_b_idx_in,
  input  core_pkg::dest_s    ex_dest_in,
  input  core_pkg::dest_s    mem_dest_in,
  input  core_pkg::dest_s    wb_dest_in,
  input  core_pkg::mem_req_s mem_req_in,
  output core_pkg::bus_req_s fetch_out,
  output core_pkg::bus_req_s data_out,
  output logic [31:0]        operand_a_out,
  output logic [31:0]        operand_b_out,
  output logic               pipe_advance_out,
  output logic               hazard_stall_out,
  output logic               bytecode_expand_out
);
  import core_pkg::*;

  // Bank: 30 general slots plus pc, one current and five saved words
  logic [31:0] gpr [0:NUM_GPR-1];
  logic [31:0] saved [0:4];
  logic [31:0] status_word;
  logic [31:0] fetch_pc;
  logic        decode_phase;
  logic [3:0]  seq_left;
  logic [7:0]  stall_cnt;
  logic [31:0] fault_addr;

  // Physical slot of an architectural index in a mode
  function automatic logic [4:0] phys_idx(input logic [3:0] idx, input logic [4:0] mode);
    logic [2:0] bank;
    bank = (mode == MODE_SVC) ? 3'h1 : (mode == MODE_ABT) ? 3'h2 :
           (mode == MODE_UND) ? 3'h3 : (mode == MODE_IRQ) ? 3'h4 :
           (mode == MODE_FIQ) ? 3'h5 : 3'h0;
    if (idx == IDX_PC) begin
      phys_idx = 5'h0;
    end else if (idx < IDX_FIRST_BANKED) begin
      phys_idx = {1'b0, idx};
    end else if (idx < IDX_SP) begin
      phys_idx = (mode == MODE_FIQ) ? 5'(idx - IDX_FIRST_BANKED) + PHYS_FIQ_HI : {1'b0, idx};
    end else begin
      phys_idx = PHYS_BANKED + {1'b0, bank, 1'b0} + 5'(idx - IDX_SP);
    end
  endfunction

  // Saved word slot of a mode; user and system have none
  function automatic logic [2:0] saved_idx(input logic [4:0] mode);
    saved_idx = (mode == MODE_SVC) ? 3'h0 : (mode == MODE_ABT) ? 3'h1 :
                (mode == MODE_UND) ? 3'h2 : (mode == MODE_IRQ) ? 3'h3 :
                (mode == MODE_FIQ) ? 3'h4 : SAVED_NONE;
  endfunction

  // Current mode, state and privilege
  wire logic [4:0] cur_mode   = status_word[4:0] & MASK_MODE[4:0];
  wire logic [2:0] cur_saved  = saved_idx(cur_mode);
  wire logic       privileged = (cur_mode != MODE_USER);
  wire istate_e    cur_state  = ((status_word & MASK_BYTECODE) != '0) ? st_bytecode :
                                ((status_word & MASK_COMPACT) != '0) ? st_compact : st_wide;

  wire logic mis_word  = (mem_req_in.size == sz_word) && ((mem_req_in.addr & ALIGN_WORD) != '0);
  wire logic mis_half  = (mem_req_in.size == sz_half) && ((mem_req_in.addr & ALIGN_HALF) != '0);
  wire logic misalign  = mem_req_in.valid && (mis_word || mis_half);

  wire logic take_dabt = exc_req_in.data_abort || misalign;
  wire logic take_fiq  = exc_req_in.fiq && ((status_word & MASK_FIQ_DIS) == '0);
  wire logic take_irq  = exc_req_in.irq && ((status_word & MASK_IRQ_DIS) == '0);
  wire logic take_pabt = exc_req_in.prefetch_abort || exc_req_in.breakpoint;
  wire logic exc_take  = take_dabt || take_fiq || take_irq || take_pabt ||
                         exc_req_in.undefined || exc_req_in.soft_int;
  wire logic [4:0] exc_mode =
    take_dabt ? MODE_ABT : take_fiq ? MODE_FIQ : take_irq ? MODE_IRQ :
    take_pabt ? MODE_ABT : exc_req_in.undefined ? MODE_UND : MODE_SVC;
  wire logic [31:0] exc_vec =
    take_dabt ? VEC_DABT : take_fiq ? VEC_FIQ : take_irq ? VEC_IRQ :
    take_pabt ? VEC_PABT : exc_req_in.undefined ? VEC_UND : VEC_SOFT;

  wire logic [31:0] status_exc = (status_word & ~(MASK_MODE | MASK_STATE)) | MASK_IRQ_DIS |
                                 ((exc_mode == MODE_FIQ) ? MASK_FIQ_DIS : '0) | {27'h0, exc_mode};

  // Branch classification
  wire logic br_valid   = branch_in.valid && !branch_in.exc_return;
  wire logic br_to_bc   = br_valid && (branch_in.kind == br_to_bytecode);
  wire logic br_native  = br_valid && (branch_in.kind != br_to_bytecode);
  // exchange and pc load switch states
  wire logic br_switch  = br_native && (cur_state != st_bytecode);
  wire logic br_enter   = br_to_bc && (cur_state == st_wide);
  wire logic [31:0] br_compact = branch_in.target[0] ? MASK_COMPACT : '0;
  wire logic [31:0] status_br  = br_enter ? (status_word | MASK_BYTECODE) :
                                 (status_word & ~MASK_COMPACT) | br_compact;
  wire logic [31:0] target_br  = br_enter ? branch_in.target :
                                 branch_in.target[0] ? (branch_in.target & ~ALIGN_HALF) :
                                 (branch_in.target & ~ALIGN_WORD);

  wire logic        exc_ret   = branch_in.valid && branch_in.exc_return && (cur_saved != SAVED_NONE);
  wire logic [31:0] saved_cur = (cur_saved == SAVED_NONE) ? '0 : saved[cur_saved];

  // software mode change only when privileged
  wire logic [4:0]  wr_mode   = reg_wdata_in[4:0] & MASK_MODE[4:0];
  wire logic        mode_ok   = (wr_mode == MODE_USER) || (wr_mode == MODE_FIQ) ||
                                (wr_mode == MODE_IRQ) || (wr_mode == MODE_SVC) ||
                                (wr_mode == MODE_ABT) || (wr_mode == MODE_UND) ||
                                (wr_mode == MODE_SYS);
  wire logic        sw_status = reg_write_in && (reg_addr_in == OFS_STATUS) && privileged && mode_ok;
  wire logic        sw_saved  = reg_write_in && (reg_addr_in == OFS_SAVED) && (cur_saved != SAVED_NONE);
  wire logic [31:0] status_sw = (reg_wdata_in & ~MASK_STATE) | (status_word & MASK_STATE);

  // Next status word by event priority
  wire logic [31:0] next_status_word =
    exc_take  ? status_exc :
    exc_ret   ? saved_cur :
    (br_enter || br_switch) ? status_br :
    sw_status ? status_sw : status_word;

  // load result not yet available stalls
  wire logic load_use = ex_dest_in.valid && ex_dest_in.is_load && (ex_dest_in.idx != IDX_PC) &&
                        ((ex_dest_in.idx == rd_a_idx_in) || (ex_dest_in.idx == rd_b_idx_in));
  // second decode cycle in bytecode state
  wire logic advance  = !load_use && ((cur_state != st_bytecode) || decode_phase);
  wire logic expanding = (seq_left != 4'h0);

  // bytecode fetches a whole aligned word
  wire logic [31:0] fetch_addr = (cur_state == st_compact) ? fetch_pc : (fetch_pc & ~ALIGN_WORD);
  wire logic [31:0] next_seq_pc = (cur_state == st_compact) ? fetch_pc + STEP_HALF :
                                  fetch_addr + STEP_WORD;
  wire logic        fetch_go    = advance && !expanding;
  wire logic [31:0] next_fetch_pc =
    exc_take ? exc_vec :
    (exc_ret || br_valid) ? target_br :
    fetch_go ? next_seq_pc : fetch_pc;

  function automatic logic [31:0] fwd(input logic [3:0] idx, input logic [31:0] bank_val);
    if (ex_dest_in.valid && !ex_dest_in.is_load && ex_dest_in.idx == idx) begin
      fwd = ex_dest_in.data;
    end else if (mem_dest_in.valid && mem_dest_in.idx == idx) begin
      fwd = mem_dest_in.data;
    end else if (wb_dest_in.valid && wb_dest_in.idx == idx) begin
      fwd = wb_dest_in.data;
    end else begin
      fwd = bank_val;
    end
  endfunction

  // system mode reads the user bank
  wire logic [4:0]  a_phys = phys_idx(rd_a_idx_in, cur_mode);
  wire logic [4:0]  b_phys = phys_idx(rd_b_idx_in, cur_mode);
  wire logic [31:0] a_bank = (rd_a_idx_in == IDX_PC) ? fetch_pc : gpr[a_phys];
  wire logic [31:0] b_bank = (rd_b_idx_in == IDX_PC) ? fetch_pc : gpr[b_phys];
  wire logic [31:0] a_val  = (rd_a_idx_in == IDX_PC) ? fetch_pc : fwd(rd_a_idx_in, a_bank);
  wire logic [31:0] b_val  = (rd_b_idx_in == IDX_PC) ? fetch_pc : fwd(rd_b_idx_in, b_bank);

  // Bank write ports
  wire logic [4:0] wb_phys  = phys_idx(wb_dest_in.idx, cur_mode);
  wire logic [4:0] lr_phys  = phys_idx(IDX_LR, cur_mode);
  wire logic [4:0] exc_lr   = phys_idx(IDX_LR, exc_mode);
  wire logic [2:0] exc_sav  = saved_idx(exc_mode);
  wire logic       wb_write = wb_dest_in.valid && (wb_dest_in.idx != IDX_PC);
  wire logic       lr_write = br_valid && (branch_in.kind == br_link_exchange);

  // Information word
  wire logic [2:0]  depth    = (cur_state == st_bytecode) ? DEPTH_BYTECODE : DEPTH_NATIVE;
  wire logic [31:0] info_word = {16'h0, stall_cnt, 1'b0, expanding, depth, privileged, cur_state};

  // Register port read decode
  wire logic [31:0] rd_mux =
    (reg_addr_in == OFS_STATUS) ? status_word :
    (reg_addr_in == OFS_SAVED)  ? saved_cur :
    (reg_addr_in == OFS_INFO)   ? info_word :
    (reg_addr_in == OFS_FAULT)  ? fault_addr : '0;

  // Handshake outputs
  assign pipe_advance_out    = advance;
  assign hazard_stall_out    = load_use;
  assign bytecode_expand_out = expanding;

  assign fetch_out.valid = fetch_go;
  assign fetch_out.coupled = ((fetch_addr & CPL_MASK) == ICPL_BASE);
  assign fetch_out.size  = (cur_state == st_compact) ? sz_half : sz_word;
  assign fetch_out.addr  = fetch_addr;

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      status_word <= STATUS_RESET;
      fetch_pc    <= VEC_RESET;
    end else begin
      status_word <= next_status_word;
      fetch_pc    <= next_fetch_pc;
    end
  end

  // link and saved word on entry
  always_ff @(posedge ref_clk_in) begin
    if (wb_write) begin
      gpr[wb_phys] <= wb_dest_in.data;
    end
    if (lr_write) begin
      gpr[lr_phys] <= branch_in.link;
    end
    if (exc_take) begin
      gpr[exc_lr]    <= exc_ret_addr_in;
      saved[exc_sav] <= status_word;
    end else if (sw_saved) begin
      saved[cur_saved] <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in || exc_take || cur_state != st_bytecode) begin
      decode_phase <= 1'b0;
    end else if (!load_use) begin
      decode_phase <= !decode_phase;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in || exc_take) begin
      seq_left <= 4'h0;
    end else if (!expanding && bytecode_rare_in && cur_state == st_bytecode) begin
      seq_left <= seq_len_in;
    end else if (expanding && !load_use) begin
      seq_left <= seq_left - 4'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      operand_a_out <= '0;
      operand_b_out <= '0;
    end else if (advance) begin
      operand_a_out <= a_val;
      operand_b_out <= b_val;
    end
  end

  // misaligned requests never reach the bus
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      data_out   <= '0;
      fault_addr <= '0;
      stall_cnt  <= '0;
    end else begin
      data_out.valid <= mem_req_in.valid && !misalign;
      data_out.coupled <= ((mem_req_in.addr & CPL_MASK) == DCPL_BASE);
      data_out.size  <= mem_req_in.size;
      data_out.addr  <= mem_req_in.addr;
      if (misalign) begin
        fault_addr <= mem_req_in.addr;
      end
      if (load_use && stall_cnt != 8'hff) begin
        stall_cnt <= stall_cnt + 8'h1;
      end
    end
  end

  // Register port read data, one cycle later
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= '0;
    end else if (reg_read_in) begin
      reg_rdata_out <= rd_mux;
    end
  end
endmodule

// ---- verif/core_state_mode_register_bank_assertions.sv ----
`timescale 1ns/1ps
module core_state_mode_register_bank_assertions
  import core_pkg::*;
(
  input wire logic          ref_clk_in,
  input wire logic          reset_n_in,
  input core_pkg::exc_req_s exc_req_in,
  input wire logic [3:0]    rd_a_idx_in,
  input core_pkg::dest_s    ex_dest_in,
  input core_pkg::mem_req_s mem_req_in,
  input core_pkg::bus_req_s fetch_out,
  input core_pkg::bus_req_s data_out,
  input wire logic [31:0]   operand_a_out,
  input wire logic          pipe_advance_out,
  input wire logic          hazard_stall_out,
  input wire logic          bytecode_expand_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Misaligned request and operand match decode
  wire mis = mem_req_in.valid && ((mem_req_in.size == sz_word && mem_req_in.addr[1:0] != 2'b00) ||
             (mem_req_in.size == sz_half && mem_req_in.addr[0]));
  wire hit_a = ex_dest_in.valid && ex_dest_in.idx == rd_a_idx_in && rd_a_idx_in != IDX_PC;

  property p_fetch_gate;
    fetch_out.valid == (pipe_advance_out && !bytecode_expand_out);
  endproperty
  property p_fetch_align;
    fetch_out.valid |-> fetch_out.size != sz_byte && !fetch_out.addr[0] &&
      (fetch_out.size != sz_word || !fetch_out.addr[1]);
  endproperty
  property p_fetch_coupled;
    fetch_out.valid |-> fetch_out.coupled == ((fetch_out.addr & CPL_MASK) == ICPL_BASE);
  endproperty
  property p_data_copy;
    mem_req_in.valid && !mis |=> data_out.valid && data_out.addr == $past(mem_req_in.addr) &&
      data_out.size == $past(mem_req_in.size) && data_out.coupled == ((data_out.addr & CPL_MASK) == DCPL_BASE);
  endproperty
  property p_data_refuse;
    mis |=> !data_out.valid && fetch_out.addr == VEC_DABT;
  endproperty
  property p_dabt_vec;
    exc_req_in.data_abort |=> fetch_out.addr == VEC_DABT;
  endproperty
  property p_load_stall;
    hit_a && ex_dest_in.is_load |-> hazard_stall_out && !pipe_advance_out;
  endproperty
  property p_forward;
    hit_a && !ex_dest_in.is_load && pipe_advance_out |=> operand_a_out == $past(ex_dest_in.data);
  endproperty
  property p_hold;
    !pipe_advance_out |=> $stable(operand_a_out);
  endproperty
  property p_expand_end;
    $rose(bytecode_expand_out) |-> ##[1:40] !bytecode_expand_out;
  endproperty

  a_fetch_gate: assert property (p_fetch_gate) else $error("fetch valid mismatch");
  a_fetch_align: assert property (p_fetch_align) else $error("bad fetch shape");
  a_fetch_coupled: assert property (p_fetch_coupled) else $error("fetch memory select");
  a_data_copy: assert property (p_data_copy) else $error("data request lost");
  a_data_refuse: assert property (p_data_refuse) else $error("misaligned passed");
  a_dabt_vec: assert property (p_dabt_vec) else $error("abort vector");
  a_load_stall: assert property (p_load_stall) else $error("no load stall");
  a_forward: assert property (p_forward) else $error("no forward");
  a_hold: assert property (p_hold) else $error("operand moved");
  a_expand_end: assert property (p_expand_end) else $error("expansion hangs");

  c_stall: cover property (hazard_stall_out);
  c_expand: cover property ($rose(bytecode_expand_out));
  c_dabt: cover property (exc_req_in.data_abort);
endmodule

bind core_state_mode_register_bank core_state_mode_register_bank_assertions u_chk (
  .ref_clk_in, .reset_n_in, .exc_req_in, .rd_a_idx_in, .ex_dest_in, .mem_req_in, .fetch_out,
  .data_out, .operand_a_out, .pipe_advance_out, .hazard_stall_out, .bytecode_expand_out
);

// ---- verif/bus_partner.sv ----
`timescale 1ns/1ps
module bus_partner
  import core_pkg::*;
(
  input wire logic          ref_clk_in,
  input wire logic          reset_n_in,
  input core_pkg::bus_req_s fetch_in,
  input core_pkg::bus_req_s data_in,
  output logic [7:0]        coupled_data_out,
  output logic [7:0]        sys_data_out,
  output logic [7:0]        bad_fetch_out
);
  wire bad = fetch_in.valid && (fetch_in.size == sz_byte || fetch_in.addr[0] ||
             (fetch_in.size == sz_word && fetch_in.addr[1]));
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      coupled_data_out <= 8'h00;
      sys_data_out  <= 8'h00;
      bad_fetch_out <= 8'h00;
    end else begin
      coupled_data_out <= coupled_data_out + 8'(data_in.valid && data_in.coupled);
      sys_data_out  <= sys_data_out + 8'(data_in.valid && !data_in.coupled);
      bad_fetch_out <= bad_fetch_out + 8'(bad);
    end
  end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import core_pkg::*;
  logic        ref_clk_in, reset_n_in, reg_write_in, reg_read_in, bytecode_rare_in;
  logic        pipe_advance_out, hazard_stall_out, bytecode_expand_out;
  logic [7:0]  reg_addr_in, n_cpl, n_sys, n_bad;
  logic [31:0] reg_wdata_in, reg_rdata_out, exc_ret_addr_in, operand_a_out, operand_b_out;
  logic [3:0]  seq_len_in, rd_a_idx_in, rd_b_idx_in;
  branch_s     branch_in;
  exc_req_s    exc_req_in;
  dest_s       ex_dest_in, mem_dest_in, wb_dest_in;
  mem_req_s    mem_req_in;
  bus_req_s    fetch_out, data_out;
  int          fails, n_checks, n;
  exc_req_s    q_tab [6] = '{7'h78, 7'h38, 7'h04, 7'h02, 7'h01, 7'h08};
  logic [31:0] s_tab [7] = '{32'h13, 32'h97, 32'hd1, 32'hd7, 32'hdb, 32'hd3, 32'hd7};
  logic [31:0] v_tab [6] = '{VEC_DABT, VEC_FIQ, VEC_PABT, VEC_UND, VEC_SOFT, VEC_PABT};

  core_state_mode_register_bank uut (.ref_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .branch_in, .exc_req_in, .exc_ret_addr_in, .bytecode_rare_in, .seq_len_in,
    .rd_a_idx_in, .rd_b_idx_in, .ex_dest_in, .mem_dest_in, .wb_dest_in, .mem_req_in, .fetch_out, .data_out,
    .operand_a_out, .operand_b_out, .pipe_advance_out, .hazard_stall_out, .bytecode_expand_out);
  bus_partner far_side (.ref_clk_in, .reset_n_in, .fetch_in(fetch_out), .data_in(data_out),
    .coupled_data_out(n_cpl), .sys_data_out(n_sys), .bad_fetch_out(n_bad));

  // Clock source
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  task close_out;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bus and pipeline drivers
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a; reg_wdata_in <= d; reg_write_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_write_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_in);
    reg_addr_in <= a; reg_read_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_read_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  task br(input br_kind_e k, input logic [31:0] t, input logic r);
    @(posedge ref_clk_in);
    branch_in <= '{1'b1, r, k, t, 32'h555};
    @(posedge ref_clk_in);
    branch_in <= '0;
    #1;
  endtask
  task exc(input exc_req_s q);
    @(posedge ref_clk_in);
    exc_req_in <= q;
    @(posedge ref_clk_in);
    exc_req_in <= '0;
    #1;
  endtask
  task wbw(input logic [3:0] i, input logic [31:0] d);
    @(posedge ref_clk_in);
    wb_dest_in <= '{1'b1, 1'b0, i, d};
    @(posedge ref_clk_in);
    wb_dest_in <= '0;
  endtask
  task rdr(input logic [3:0] i, input logic [31:0] e);
    @(posedge ref_clk_in);
    rd_a_idx_in <= i;
    @(posedge ref_clk_in);
    #1 chk(operand_a_out, e);
  endtask
  task mem(input logic w, input size_e s, input logic [31:0] a, input logic ev, input logic et);
    @(posedge ref_clk_in);
    mem_req_in <= '{1'b1, w, s, a};
    @(posedge ref_clk_in);
    mem_req_in <= '0;
    #1 chk(32'(data_out.valid), 32'(ev));
    if (ev) chk(32'(data_out.coupled), 32'(et));
  endtask
  // Scenarios
  task t_reset;
    rd(OFS_STATUS, STATUS_RESET);
    rd(OFS_INFO, 32'h2c);
    wr(OFS_INFO, 32'hffff_ffff);
    rd(OFS_INFO, 32'h2c);
    rd(8'h20, 32'h0);
  endtask
  task t_hazard;
    @(posedge ref_clk_in);
    ex_dest_in <= '{1'b1, 1'b1, 4'h3, 32'h0}; rd_a_idx_in <= 4'h3;
    #1 chk({hazard_stall_out, pipe_advance_out}, 32'h2);
    @(posedge ref_clk_in);
    ex_dest_in <= '{1'b1, 1'b1, 4'h6, 32'h0}; rd_b_idx_in <= 4'h6;
    #1 chk({hazard_stall_out, pipe_advance_out}, 32'h2);
    @(posedge ref_clk_in);
    ex_dest_in <= '{1'b1, 1'b0, 4'h4, 32'h1111_1111}; mem_dest_in <= '{1'b1, 1'b0, 4'h4, 32'h2222_2222};
    rd_a_idx_in <= 4'h4;
    @(posedge ref_clk_in);
    ex_dest_in <= '0;
    #1 chk(operand_a_out, 32'h1111_1111);
    @(posedge ref_clk_in);
    mem_dest_in <= '0;
    #1 chk(operand_a_out, 32'h2222_2222);
    rd(OFS_INFO, 32'h22c);
  endtask
  task t_bank;
    wbw(4'h8, 32'ha0a0_0008); wbw(4'hd, 32'hb0b0_000d);
    wr(OFS_STATUS, 32'h1f);
    rdr(4'h8, 32'ha0a0_0008);
    wbw(4'hd, 32'hc0c0_000d);
    rdr(4'hd, 32'hc0c0_000d);
    rd(OFS_SAVED, 32'h0);
    wr(OFS_STATUS, 32'h11);
    wbw(4'h8, 32'hd0d0_0008);
    wbw(4'h6, 32'h6666_0006);
    wr(OFS_STATUS, 32'h13);
    rdr(4'h8, 32'ha0a0_0008);
    chk(operand_b_out, 32'h6666_0006);
    rdr(4'hd, 32'hb0b0_000d);
    wr(OFS_STATUS, 32'h10); wr(OFS_STATUS, 32'h13);
    rd(OFS_STATUS, 32'h10);
    exc(7'h01);
    chk(fetch_out.addr, VEC_SOFT);
    rd(OFS_STATUS, 32'h93);
    rd(OFS_SAVED, 32'h10);
    wr(OFS_SAVED, 32'h0000_001f);
    rd(OFS_SAVED, 32'h0000_001f);
  endtask
  task t_modes;
    wr(OFS_STATUS, 32'h13);
    for (int i = 0; i < 6; i++) begin
      exc(q_tab[i]);
      chk(fetch_out.addr, v_tab[i]);
      rd(OFS_STATUS, s_tab[i + 1]);
      rd(OFS_SAVED, s_tab[i]);
    end
  endtask
  task t_exchange;
    wr(OFS_STATUS, 32'h13);
    for (int k = 0; k < 3; k++) begin
      br(br_kind_e'(k), 32'h101, 1'b0);
      chk({fetch_out.addr, 30'h0, fetch_out.size}, {32'h100, 32'(sz_half)});
      rd(OFS_INFO, 32'h22d);
      br(br_kind_e'(k), 32'h200, 1'b0);
      chk({fetch_out.addr, 30'h0, fetch_out.size}, {32'h200, 32'(sz_word)});
      rd(OFS_INFO, 32'h22c);
    end
    rdr(IDX_LR, 32'h555);
  endtask
  task t_bytecode;
    br(br_to_bytecode, 32'h301, 1'b0);
    chk({fetch_out.addr, 30'h0, fetch_out.size}, {32'h300, 32'(sz_word)});
    rd(OFS_STATUS, 32'h0100_0013);
    rd(OFS_INFO, 32'h236);
    n = 0;
    repeat (8) begin
      @(posedge ref_clk_in);
      #1 if (pipe_advance_out === 1'b1) n++;
    end
    chk(n, 4);
    br(br_exchange, 32'h401, 1'b0);
    wr(OFS_STATUS, 32'h33);
    rd(OFS_STATUS, 32'h0100_0013);
    @(posedge ref_clk_in);
    bytecode_rare_in <= 1'b1; seq_len_in <= 4'h3;
    @(posedge ref_clk_in);
    bytecode_rare_in <= 1'b0;
    #1 chk(32'(bytecode_expand_out), 32'h1);
    n = 0;
    while (bytecode_expand_out === 1'b1 && n < 40) begin
      n++;
      @(posedge ref_clk_in);
      #1;
    end
    chk(32'(bytecode_expand_out), 32'h0);
    exc(7'h10);
    chk(fetch_out.addr, VEC_IRQ);
    rd(OFS_STATUS, 32'h92);
    rd(OFS_SAVED, 32'h0100_0013);
    br(br_exchange, 32'h500, 1'b1);
    rd(OFS_STATUS, 32'h0100_0013);
  endtask
  task t_mem;
    mem(1'b0, sz_word, 32'h0010_0004, 1'b1, 1'b1);
    mem(1'b1, sz_byte, 32'h0000_0203, 1'b1, 1'b0);
    mem(1'b0, sz_word, 32'h0000_0102, 1'b0, 1'b0);
    mem(1'b0, sz_half, 32'h0000_0201, 1'b0, 1'b0);
    rd(OFS_FAULT, 32'h201);
    rd(OFS_STATUS, 32'h97);
    chk({n_cpl, n_sys, n_bad}, 32'h0001_0100);
  endtask
  // Main sequence
  initial begin
    fails = 0; n_checks = 0; reset_n_in = 1'b0; reg_write_in = 1'b0; reg_read_in = 1'b0;
    reg_addr_in = '0; reg_wdata_in = '0; branch_in = '0; exc_req_in = '0; exc_ret_addr_in = 32'habc;
    bytecode_rare_in = 1'b0; seq_len_in = '0; rd_a_idx_in = '0; rd_b_idx_in = '0; mem_req_in = '0;
    ex_dest_in = '0; mem_dest_in = '0; wb_dest_in = '0;
    repeat (20) @(posedge ref_clk_in);
    chk(fetch_out.addr, VEC_RESET);
    reset_n_in <= 1'b1;
    t_reset; t_hazard; t_bank; t_modes; t_exchange; t_bytecode; t_mem;
    close_out;
  end
  // Watchdog
  initial begin
    #100000;
    fails++;
    close_out;
  end
endmodule
